// ### rtl/check_clock_divider.v
// Divides the oscillator clock by two raised to a selected exponent.
`timescale 1ns/1ns
`include "crc_monitor_defs.vh"

module check_clock_divider (
    input  wire                  clk,
    input  wire                  rst,
    input  wire [`DIV_EXP_W-1:0] div_exp,
    output reg                   tick
);

    reg  [`DIV_CNT_W-1:0] cnt_r;
    reg  [`DIV_EXP_W-1:0] exp_eff;
    wire [`DIV_CNT_W-1:0] cnt_last;
    wire [`DIV_CNT_W:0]   cnt_full;

    // An exponent outside 1..8 is clamped so the divisor stays 2..256.
    always @* begin
        if (div_exp < `DIV_EXP_MIN) begin
            exp_eff = `DIV_EXP_MIN;
        end else if (div_exp > `DIV_EXP_MAX) begin
            exp_eff = `DIV_EXP_MAX;
        end else begin
            exp_eff = div_exp;
        end
    end

    assign cnt_full = (9'h001 << exp_eff) - 9'h001;
    assign cnt_last = cnt_full[`DIV_CNT_W-1:0];

    // One tick per divided period; the tick is the checker clock enable.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 8'h00;
            tick  <= 1'b0;
        end else if (cnt_r >= cnt_last) begin
            cnt_r <= 8'h00;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 8'h01;
            tick  <= 1'b0;
        end
    end

endmodule

// ### rtl/config_memory_crc_monitor.v
// Configuration memory CRC monitor: scans frames, reports errors on a flag.
//
// Overview of operation
// - Start checking on entry to user mode while check enable is high.
// - Raise flag after search and message update.
// - Flag low at least 32 checker clocks.
// - Next failing frame overwrites message, reraises flag.
// - Scan frames continuously until device reset.
// - Checker clock is oscillator over two to n.
// - Divisor is a power of two, 2..256.
// - Checker clock between 390 kHz and 50 MHz.
// - CRC is evaluated one frame at a time.
// - Pass time scales with the selected divisor.
// - Enable routes error indication to output pin.
// - Non-zero syndrome drives the error flag.
// - Message holds type, location and syndrome, 46 bits.
`timescale 1ns/1ns
`include "crc_monitor_defs.vh"

module config_memory_crc_monitor (
    input  wire                   clk,
    input  wire                   rst,
    input  wire                   check_enable,
    input  wire                   user_mode,
    input  wire [`DIV_EXP_W-1:0]  div_exp,
    output reg  [`FRAME_CNT_W-1:0] frame_addr,
    output reg  [`BIT_IDX_W-1:0]  bit_addr,
    input  wire                   frame_bit,
    input  wire [`CRC_W-1:0]      stored_crc,
    output reg                    crc_error,
    output wire                   crc_error_pin_o,
    output wire                   crc_error_pin_oe_n,
    output reg  [`MSG_W-1:0]      err_msg,
    output reg  [`CRC_W-1:0]      syndrome
);

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers for pin-level controls and the frame data bit.

    reg                  en_s1_r;
    reg                  en_s2_r;
    reg                  um_s1_r;
    reg                  um_s2_r;
    reg                  fb_s1_r;
    reg                  fb_s2_r;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            en_s1_r <= 1'b0;
            en_s2_r <= 1'b0;
            um_s1_r <= 1'b0;
            um_s2_r <= 1'b0;
            fb_s1_r <= 1'b0;
            fb_s2_r <= 1'b0;
        end else begin
            en_s1_r <= check_enable;
            en_s2_r <= en_s1_r;
            um_s1_r <= user_mode;
            um_s2_r <= um_s1_r;
            fb_s1_r <= frame_bit;
            fb_s2_r <= fb_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checker clock enable.

    wire                 tick;

    check_clock_divider u_div (
        .clk     (clk),
        .rst     (rst),
        .div_exp (div_exp),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////
    // Scan state machine.

    localparam [5:0] ST_IDLE   = 6'h01;
    localparam [5:0] ST_SCAN   = 6'h02;
    localparam [5:0] ST_CHECK  = 6'h04;
    localparam [5:0] ST_SEARCH = 6'h08;
    localparam [5:0] ST_REPORT = 6'h10;
    localparam [5:0] ST_LOW    = 6'h20;

    reg  [5:0]              state_r;
    reg  [5:0]              state_nxt;
    reg  [`FLAG_LOW_W-1:0]  low_cnt_r;
    reg  [`BIT_IDX_W-1:0]   err_bit_r;
    reg  [1:0]              err_type_r;
    reg                     crc_clear;
    reg                     crc_step;
    wire [`CRC_W-1:0]       crc_val;
    wire [`CRC_W-1:0]       syn_now;
    wire                    last_bit;
    wire                    last_frame;

    // The data pin lags the address by two clocks through the synchroniser,
    // so with a divisor of 2 every step sees the bit of the previous address;
    // from a divisor of 4 up, the new bit has settled before the next step.
    frame_crc u_crc (
        .clk      (clk),
        .rst      (rst),
        .clear    (crc_clear),
        .step     (crc_step),
        .data_bit (fb_s2_r),
        .crc      (crc_val)
    );

    assign syn_now    = crc_val ^ stored_crc;
    assign last_bit   = (bit_addr == `FRAME_BITS - 16'h0001);
    assign last_frame = (frame_addr == `NUM_FRAMES - 16'h0001);
    assign crc_error_pin_o    = crc_error;
    assign crc_error_pin_oe_n = ~en_s2_r;

    always @* begin
        state_nxt = state_r;
        crc_clear = 1'b0;
        crc_step  = 1'b0;
        case (state_r)
            ST_IDLE: begin
                crc_clear = 1'b1;
                if (en_s2_r && um_s2_r) begin
                    state_nxt = ST_SCAN;
                end
            end
            ST_SCAN: begin
                crc_step = tick;
                if (tick && last_bit) begin
                    state_nxt = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (tick) begin
                    crc_clear = (syn_now == 16'h0000);
                    if (syn_now != 16'h0000) begin
                        state_nxt = ST_SEARCH;
                    end else begin
                        state_nxt = ST_SCAN;
                    end
                end
            end
            ST_SEARCH: begin
                if (tick) begin
                    crc_clear = 1'b1;
                    state_nxt = ST_REPORT;
                end
            end
            ST_REPORT: begin
                if (tick) begin
                    state_nxt = ST_LOW;
                end
            end
            ST_LOW: begin
                // No CRC steps here: the address is parked, so stepping
                // would fold stale bits into the next frame's signature.
                if (tick && low_cnt_r == `FLAG_LOW_CLKS - 6'h01) begin
                    state_nxt = ST_SCAN;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Location search: a single-bit syndrome is located by its bit index,
    // anything else is reported as a multi-bit error with no location.
    integer i;
    always @* begin
        err_type_r = `ERR_MULTI;
        err_bit_r  = 12'h000;
        for (i = 0; i < `CRC_W; i = i + 1) begin
            if (syndrome == (16'h0001 << i)) begin
                err_type_r = `ERR_SINGLE;
                err_bit_r  = i[`BIT_IDX_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequential state, addresses, message and flag.

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r    <= ST_IDLE;
            frame_addr <= 16'h0000;
            bit_addr   <= 12'h000;
            low_cnt_r  <= 6'h00;
            syndrome   <= 16'h0000;
            err_msg    <= 46'h0;
            crc_error  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_SCAN && tick) begin
                bit_addr <= last_bit ? 12'h000 : bit_addr + 12'h001;
            end
            if (state_r == ST_CHECK && tick) begin
                syndrome   <= syn_now;
                frame_addr <= last_frame ? 16'h0000 : frame_addr + 16'h0001;
            end
            if (state_r == ST_SEARCH && tick) begin
                err_msg[`MSG_TYPE_HI:`MSG_TYPE_LO] <= err_type_r;
                err_msg[`MSG_FRAME_HI:`MSG_FRAME_LO] <=
                    (frame_addr == 16'h0000) ? `NUM_FRAMES - 16'h0001
                                             : frame_addr - 16'h0001;
                err_msg[`MSG_BIT_HI:`MSG_BIT_LO] <= err_bit_r;
                err_msg[`MSG_SYN_HI:`MSG_SYN_LO] <= syndrome;
            end
            if (state_r == ST_REPORT && tick) begin
                crc_error <= 1'b1;
            end
            if (state_r == ST_LOW) begin
                crc_error <= 1'b0;
                if (tick) begin
                    low_cnt_r <= low_cnt_r + 6'h01;
                end
            end else begin
                low_cnt_r <= 6'h00;
            end
        end
    end

endmodule

// ### rtl/crc_monitor_defs.vh
// Constants for the configuration memory CRC monitor.
`ifndef CRC_MONITOR_DEFS_VH
`define CRC_MONITOR_DEFS_VH

// Oscillator and checker clock figures, in MHz and kHz.
`define OSC_FREQ_MHZ          100
`define CHK_FREQ_MAX_MHZ      50
`define CHK_FREQ_MIN_KHZ      390
// Divider exponent limits and width.
`define DIV_EXP_W             4
`define DIV_EXP_MIN           4'h1
`define DIV_EXP_MAX           4'h8
`define DIV_CNT_W             8
// Low time of the error flag between reports, in checker clocks.
`define FLAG_LOW_CLKS         6'h20
`define FLAG_LOW_W            6
// Frame geometry.
`define FRAME_BITS            16'h0040
`define FRAME_CNT_W           16
`define NUM_FRAMES            16'h0010
`define CRC_W                 16
`define CRC_POLY              16'h1021
`define CRC_INIT              16'hffff
// Error message layout: type [45:44], frame [43:28], bit [27:16], syndrome.
`define MSG_W                 46
`define MSG_TYPE_HI           45
`define MSG_TYPE_LO           44
`define MSG_FRAME_HI          43
`define MSG_FRAME_LO          28
`define MSG_BIT_HI            27
`define MSG_BIT_LO            16
`define MSG_SYN_HI            15
`define MSG_SYN_LO            0
`define BIT_IDX_W             12
// Error type codes.
`define ERR_NONE              2'h0
`define ERR_SINGLE            2'h1
`define ERR_MULTI             2'h3

`endif

// ### rtl/frame_crc.v
// Serial CRC engine for one configuration frame.
`timescale 1ns/1ns
`include "crc_monitor_defs.vh"

module frame_crc (
    input  wire              clk,
    input  wire              rst,
    input  wire              clear,
    input  wire              step,
    input  wire              data_bit,
    output reg  [`CRC_W-1:0] crc
);

    wire fb;

    assign fb = crc[`CRC_W-1] ^ data_bit;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            crc <= `CRC_INIT;
        end else if (clear) begin
            crc <= `CRC_INIT;
        end else if (step) begin
            crc <= {crc[`CRC_W-2:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
        end
    end

endmodule

// ### testbench/cram_model.sv
// Far-side model: cell contents, stored CRCs and a restart controller.
`timescale 1ns/1ns
module cram_model (
    input  wire        clk,
    input  wire [15:0] frame_addr,
    input  wire [11:0] bit_addr,
    input  wire [15:0] bad_mask,
    input  wire        crc_error,
    input  wire        allow_restart,
    output wire        frame_bit,
    output wire [15:0] stored_crc,
    output reg         config_restart_n
);
    reg [63:0] mem [0:15];
    reg [15:0] good [0:15];
    reg        flag_d;
    integer    seed, f, b;
    initial begin
        seed = 33;
        flag_d = 1'b0;
        config_restart_n = 1'b1;
        for (f = 0; f < 16; f = f + 1) begin
            mem[f] = {$random(seed), $random(seed)};
            good[f] = 16'hffff;
            for (b = 0; b < 64; b = b + 1)
                good[f] = {good[f][14:0], 1'b0} ^
                          ((good[f][15] ^ mem[f][b]) ? 16'h1021 : 16'h0);
        end
    end
    assign frame_bit  = mem[frame_addr[3:0]][bit_addr[5:0]];
    // Flipping bit 0 in chosen frames gives a known syndrome of one.
    assign stored_crc = good[frame_addr[3:0]] ^
                        {15'h0, bad_mask[frame_addr[3:0]]};
    always @(posedge clk) begin
        flag_d           <= crc_error;
        config_restart_n <= !(allow_restart && crc_error && !flag_d);
    end
endmodule

// ### testbench/crc_monitor_props.sv
// Port assertions for the configuration memory CRC monitor.
`timescale 1ns/1ns
module crc_monitor_props (
    input wire        clk,
    input wire        rst,
    input wire        check_enable,
    input wire        user_mode,
    input wire [3:0]  div_exp,
    input wire [15:0] frame_addr,
    input wire [11:0] bit_addr,
    input wire        frame_bit,
    input wire [15:0] stored_crc,
    input wire        crc_error,
    input wire        crc_error_pin_o,
    input wire        crc_error_pin_oe_n,
    input wire [45:0] err_msg,
    input wire [15:0] syndrome
);
    wire [3:0]  dx = (div_exp < 4'h1) ? 4'h1 :
                     (div_exp > 4'h8) ? 4'h8 : div_exp;
    reg  [15:0] low_r, stall_r, fa_r;
    reg         ran_r;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            low_r   <= 16'h0;
            stall_r <= 16'h0;
            fa_r    <= 16'h0;
            ran_r   <= 1'b0;
        end else begin
            // Saturate so a long quiet spell never wraps into a short one.
            low_r   <= crc_error ? 16'h0 : low_r + {15'h0, low_r != 16'hffff};
            stall_r <= (fa_r != frame_addr || !ran_r) ? 16'h0 : stall_r + 16'h1;
            fa_r    <= frame_addr;
            ran_r   <= ran_r | (check_enable & user_mode);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    flag_pulse_a: assert property (
        $rose(crc_error) |=> !crc_error) else $error("flag too long");
    flag_gap_a: assert property (
        $rose(crc_error) |-> low_r >= (16'h20 << dx)) else $error("gap short");
    flag_cause_a: assert property (
        $rose(crc_error) |-> syndrome != 16'h0) else $error("flag no cause");
    msg_syndrome_a: assert property (
        $rose(crc_error) |-> err_msg[15:0] == syndrome && err_msg[45:44] != 2'h0)
        else $error("message syndrome");
    msg_frame_a: assert property (
        $rose(crc_error) |-> err_msg[43:28] + 16'h1 == frame_addr ||
        frame_addr == 16'h0 && err_msg[43:28] == 16'hf) else $error("frame");
    msg_first_a: assert property (
        !$stable(err_msg) |-> !crc_error ##[1:520] $rose(crc_error))
        else $error("message without flag");
    idle_quiet_a: assert property (
        !ran_r |-> !crc_error && frame_addr == 16'h0) else $error("not idle");
    scan_alive_a: assert property (
        stall_r <= (16'd120 << dx)) else $error("scan stalled");
    pin_copy_a: assert property (
        crc_error_pin_o == crc_error) else $error("pin copy");
    pin_drive_a: assert property (
        check_enable [*5] |-> !crc_error_pin_oe_n) else $error("pin undriven");
endmodule
bind config_memory_crc_monitor crc_monitor_props props (
    .clk(clk), .rst(rst), .check_enable(check_enable),
    .user_mode(user_mode), .div_exp(div_exp), .frame_addr(frame_addr),
    .bit_addr(bit_addr), .frame_bit(frame_bit), .stored_crc(stored_crc),
    .crc_error(crc_error), .crc_error_pin_o(crc_error_pin_o),
    .crc_error_pin_oe_n(crc_error_pin_oe_n), .err_msg(err_msg),
    .syndrome(syndrome));

// ### testbench/testbench.sv
// Self-checking bench for the configuration memory CRC monitor.
`timescale 1ns/1ns
module testbench;
    reg         clk, rst_b, check_enable, user_mode, allow_restart, flag_q;
    reg  [3:0]  div_exp;
    reg  [15:0] bad_mask, exp_f;
    reg  [15:0] exp_q [$];
    wire [15:0] frame_addr, stored_crc, syndrome;
    wire [11:0] bit_addr;
    wire [45:0] err_msg;
    wire        frame_bit, crc_error, pin_o, pin_oe_n, config_restart_n;
    wire        rst = rst_b | !config_restart_n;
    integer     mismatches, total_checks, cycles, reports;
    config_memory_crc_monitor dut (.clk(clk), .rst(rst),
        .check_enable(check_enable), .user_mode(user_mode),
        .div_exp(div_exp), .frame_addr(frame_addr), .bit_addr(bit_addr),
        .frame_bit(frame_bit), .stored_crc(stored_crc),
        .crc_error(crc_error), .crc_error_pin_o(pin_o),
        .crc_error_pin_oe_n(pin_oe_n), .err_msg(err_msg),
        .syndrome(syndrome));
    cram_model far (.clk(clk), .frame_addr(frame_addr), .bit_addr(bit_addr),
        .bad_mask(bad_mask), .crc_error(crc_error),
        .allow_restart(allow_restart), .frame_bit(frame_bit),
        .stored_crc(stored_crc), .config_restart_n(config_restart_n));
    task check(input [45:0] got, input [45:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task end_sim;
        begin
            if (mismatches == 0 && total_checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    // The message is read at each rising flag, before the next can land.
    always @(posedge clk) begin
        flag_q <= crc_error;
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches = mismatches + 1;
            end_sim;
        end
        if (crc_error === 1'b1 && flag_q === 1'b0) begin
            exp_f = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hffff;
            reports = reports + 1;
            check(err_msg[43:28], exp_f);
            check(err_msg[15:0], 16'h1);
            check(err_msg[45:44], 2'h1);
            check(err_msg[27:16], 12'h0);
            check(pin_o, 1'b1);
        end
    end
    initial begin
        mismatches = 0;
        total_checks = 0;
        cycles = 0;
        reports = 0;
        rst_b = 1'b1;
        flag_q = 1'b0;
        check_enable = 1'b0;
        user_mode = 1'b0;
        allow_restart = 1'b0;
        div_exp = 4'h2;
        bad_mask = 16'h0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b0;
        repeat (100) @(posedge clk);
        check(frame_addr, 16'h0);
        // Frames 3 and 4 fail back to back; frame 15 fails at the wrap.
        exp_q = {16'h3, 16'h4, 16'hf, 16'h3, 16'h4, 16'hf, 16'h3};
        bad_mask <= 16'h8018;
        check_enable <= 1'b1;
        user_mode <= 1'b1;
        repeat (40) @(posedge clk);
        check_enable <= 1'b0;
        user_mode <= 1'b0;
        while (reports < 6) @(posedge clk);
        allow_restart <= 1'b1;
        while (config_restart_n !== 1'b0) @(posedge clk);
        repeat (200) @(posedge clk);
        check(err_msg, 46'h0);
        check(frame_addr, 16'h0);
        check({45'h0, exp_q.size() == 0}, 46'h1);
        end_sim;
    end
endmodule
